// *** axu_pkg.sv ***
// Function
// - machine rests idle after reset and between transactions
// - from idle read request wins, then write, else stay idle
// - write state drives awvalid/awaddr and wvalid/wdata/wstrb
// - write leaves to ack only when bvalid and bready both high
// - slverr write response raises the write error indication
// - read state drives arvalid/araddr, leaves on rvalid and rready
// - slverr read response raises the read error indication
// - ack state always returns to idle next cycle
// - reset is active low and synchronous to the clock
// - address and data buses are 32 bits wide
// - responses are 2 bits: okay, exokay, slverr, decerr
package axu_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int RESP_W = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_EXOKAY = 2'h1;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   localparam logic [31:0] RST_ADDR = 32'h0000_0000;
   localparam logic [31:0] RST_DATA = 32'h0000_0000;
   localparam logic [3:0] RST_STRB = 4'h0;
   localparam logic [1:0] RST_RESP = 2'h0;
   typedef enum logic [3:0] {
      AXU_IDLE = 4'h1,
      AXU_WRITE = 4'h2,
      AXU_READ = 4'h4,
      AXU_ACK = 4'h8
   } axu_state_t;
endpackage : axu_pkg

// *** axu_chan.sv ***
`timescale 1ns/1ps
// one valid/ready request channel: raise on start, hold until ready
module axu_chan #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // control
   input wire logic start,
   input wire logic [W-1:0] payload,
   // channel
   input wire logic ready,
   output logic valid,
   output logic [W-1:0] data
);
   typedef struct packed {
      logic valid;
      logic [W-1:0] data;
   } axu_chan_st_t;
   axu_chan_st_t st_ff;
   axu_chan_st_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (st_ff.valid && ready) begin
         nxt_st.valid = 1'b0;
      end else if (start && !st_ff.valid) begin
         nxt_st.valid = 1'b1;
         nxt_st.data = payload;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign valid = st_ff.valid;
   assign data = st_ff.data;

   property p_hold;
      @(posedge core_clk) disable iff (!rstn)
      (valid && !ready) |=> (valid && $stable(data));
   endproperty
   a_hold: assert property (p_hold) else $error("early drop");
endmodule : axu_chan

// *** axu_access_fsm.sv ***
`timescale 1ns/1ps
module axu_access_fsm (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // user requests
   input wire logic user_read_req,
   input wire logic user_write_req,
   input wire logic [31:0] user_addr,
   input wire logic [31:0] user_wdata,
   input wire logic [3:0] user_wstrb,
   // user answers
   output logic user_done,
   output logic [31:0] user_rdata,
   output logic user_rd_err,
   output logic user_wr_err,
   output logic user_busy,
   // axi4-lite write address
   output logic s_axi_awvalid,
   output logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awready,
   // axi4-lite write data
   output logic s_axi_wvalid,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wready,
   // axi4-lite write response
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // axi4-lite read address
   output logic s_axi_arvalid,
   output logic [31:0] s_axi_araddr,
   input wire logic s_axi_arready,
   // axi4-lite read data
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   typedef struct packed {
      axu_pkg::axu_state_t state;
      logic done;
      logic [31:0] rdata;
      logic rd_err;
      logic wr_err;
      logic bready;
      logic rready;
      logic busy;
   } axu_st_t;
   axu_st_t st_ff;
   axu_st_t nxt_st;

   logic start_wr;
   logic start_rd;
   logic b_hs;
   logic r_hs;
   logic [35:0] w_bus;

   assign b_hs = s_axi_bvalid && st_ff.bready;
   assign r_hs = s_axi_rvalid && st_ff.rready;

   always_comb begin
      nxt_st = st_ff;
      start_wr = 1'b0;
      start_rd = 1'b0;
      nxt_st.done = 1'b0;
      case (st_ff.state)
         axu_pkg::AXU_IDLE: begin
            nxt_st.bready = 1'b0;
            nxt_st.rready = 1'b0;
            if (user_read_req) begin
               nxt_st.state = axu_pkg::AXU_READ;
               nxt_st.rready = 1'b1;
               start_rd = 1'b1;
            end else if (user_write_req) begin
               nxt_st.state = axu_pkg::AXU_WRITE;
               nxt_st.bready = 1'b1;
               start_wr = 1'b1;
            end
         end
         axu_pkg::AXU_WRITE: begin
            if (b_hs) begin
               nxt_st.state = axu_pkg::AXU_ACK;
               nxt_st.bready = 1'b0;
               nxt_st.wr_err = (s_axi_bresp == axu_pkg::RESP_SLVERR);
            end
         end
         axu_pkg::AXU_READ: begin
            if (r_hs) begin
               nxt_st.state = axu_pkg::AXU_ACK;
               nxt_st.rready = 1'b0;
               nxt_st.rdata = s_axi_rdata;
               nxt_st.rd_err = (s_axi_rresp == axu_pkg::RESP_SLVERR);
            end
         end
         axu_pkg::AXU_ACK: begin
            nxt_st.state = axu_pkg::AXU_IDLE;
            nxt_st.done = 1'b1;
         end
         default: begin
            nxt_st.state = axu_pkg::AXU_IDLE;
         end
      endcase
      // busy kept in a flop so the output is glitch free
      nxt_st.busy = (nxt_st.state != axu_pkg::AXU_IDLE);
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_ff.state <= axu_pkg::AXU_IDLE;
         st_ff.done <= 1'b0;
         st_ff.rdata <= axu_pkg::RST_DATA;
         st_ff.rd_err <= 1'b0;
         st_ff.wr_err <= 1'b0;
         st_ff.bready <= 1'b0;
         st_ff.rready <= 1'b0;
         st_ff.busy <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   axu_chan #(.W(32)) u_aw (
      .core_clk(core_clk),
      .rstn(rstn),
      .start(start_wr),
      .payload(user_addr),
      .ready(s_axi_awready),
      .valid(s_axi_awvalid),
      .data(s_axi_awaddr)
   );

   axu_chan #(.W(36)) u_w (
      .core_clk(core_clk),
      .rstn(rstn),
      .start(start_wr),
      .payload({user_wstrb, user_wdata}),
      .ready(s_axi_wready),
      .valid(s_axi_wvalid),
      .data(w_bus)
   );

   axu_chan #(.W(32)) u_ar (
      .core_clk(core_clk),
      .rstn(rstn),
      .start(start_rd),
      .payload(user_addr),
      .ready(s_axi_arready),
      .valid(s_axi_arvalid),
      .data(s_axi_araddr)
   );

   assign s_axi_bready = st_ff.bready;
   assign s_axi_rready = st_ff.rready;
   assign s_axi_wstrb = w_bus[35:32];
   assign s_axi_wdata = w_bus[31:0];
   assign user_done = st_ff.done;
   assign user_rdata = st_ff.rdata;
   assign user_rd_err = st_ff.rd_err;
   assign user_wr_err = st_ff.wr_err;
   assign user_busy = st_ff.busy;

   property p_rst_idle;
      @(posedge core_clk) !rstn |=> (st_ff.state == axu_pkg::AXU_IDLE);
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("not idle");

   property p_rd_prio;
      @(posedge core_clk) disable iff (!rstn)
      (st_ff.state == axu_pkg::AXU_IDLE && user_read_req)
         |=> (st_ff.state == axu_pkg::AXU_READ) && s_axi_arvalid;
   endproperty
   a_rd_prio: assert property (p_rd_prio) else $error("no read");

   property p_wr_start;
      @(posedge core_clk) disable iff (!rstn)
      (st_ff.state == axu_pkg::AXU_IDLE && !user_read_req && user_write_req)
         |=> s_axi_awvalid && s_axi_wvalid && s_axi_awaddr == $past(user_addr);
   endproperty
   a_wr_start: assert property (p_wr_start) else $error("no write");

   property p_wr_ack;
      @(posedge core_clk) disable iff (!rstn)
      (st_ff.state == axu_pkg::AXU_WRITE && !b_hs)
         |=> (st_ff.state == axu_pkg::AXU_WRITE);
   endproperty
   a_wr_ack: assert property (p_wr_ack) else $error("early ack");

   property p_wr_err;
      @(posedge core_clk) disable iff (!rstn)
      (st_ff.state == axu_pkg::AXU_WRITE && b_hs)
         |=> user_wr_err == ($past(s_axi_bresp) == 2'h2) ##1 user_done;
   endproperty
   a_wr_err: assert property (p_wr_err) else $error("write error");

   property p_rd_err;
      @(posedge core_clk) disable iff (!rstn)
      (st_ff.state == axu_pkg::AXU_READ && r_hs)
         |=> user_rd_err == ($past(s_axi_rresp) == 2'h2)
             && user_rdata == $past(s_axi_rdata);
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("read error");

   property p_ack_idle;
      @(posedge core_clk) disable iff (!rstn)
      (st_ff.state == axu_pkg::AXU_ACK)
         |=> (st_ff.state == axu_pkg::AXU_IDLE) && user_done;
   endproperty
   a_ack_idle: assert property (p_ack_idle) else $error("no idle");

   property p_rd_hold;
      @(posedge core_clk) disable iff (!rstn)
      (s_axi_arvalid && !s_axi_arready) |=> s_axi_arvalid;
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("ar drop");

   c_wr: cover property (@(posedge core_clk) disable iff (!rstn)
      st_ff.state == axu_pkg::AXU_WRITE && b_hs);
   c_rd: cover property (@(posedge core_clk) disable iff (!rstn)
      st_ff.state == axu_pkg::AXU_READ && r_hs);
   c_rd_err: cover property (@(posedge core_clk) disable iff (!rstn)
      user_rd_err && user_done);
endmodule : axu_access_fsm

// *** axu_slave_model.sv ***
`timescale 1ns/1ps
// register-map slave; wait_cyc stalls every address accept
module axu_slave_model (
   // clock, reset and pacing
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [3:0] wait_cyc,
   // write side
   input wire logic s_axi_awvalid,
   input wire logic [31:0] s_axi_awaddr,
   output logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read side
   input wire logic s_axi_arvalid,
   input wire logic [31:0] s_axi_araddr,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [31:0] mem [0:15];
   logic [3:0] wcnt;
   logic [3:0] rcnt;
   function automatic logic [1:0] resp(input logic [31:0] a);
      if (a[31:6] == 26'h0) return axu_pkg::RESP_OKAY;
      return a[31] ? a[29:28] : axu_pkg::RESP_SLVERR;
   endfunction : resp
   always @(posedge core_clk) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      if (!rstn) begin
         {s_axi_bvalid, s_axi_rvalid, wcnt, rcnt} <= '0;
         {s_axi_bresp, s_axi_rresp, s_axi_rdata} <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
             && !s_axi_bvalid) begin
            wcnt <= (wcnt == wait_cyc) ? 4'h0 : wcnt + 4'h1;
            s_axi_awready <= (wcnt == wait_cyc);
            s_axi_wready <= (wcnt == wait_cyc);
         end
         if (s_axi_awready) begin
            for (int i = 0; i < 4; i++)
               if (s_axi_wstrb[i] && resp(s_axi_awaddr) == 2'h0)
                  mem[s_axi_awaddr[5:2]][8*i+:8] <= s_axi_wdata[8*i+:8];
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= resp(s_axi_awaddr);
         end
         // released lines flip so stale values never pass
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ~s_axi_bresp;
         end
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            rcnt <= (rcnt == wait_cyc) ? 4'h0 : rcnt + 4'h1;
            s_axi_arready <= (rcnt == wait_cyc);
         end
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= resp(s_axi_araddr);
            s_axi_rdata <= (resp(s_axi_araddr) == 2'h0) ?
               mem[s_axi_araddr[5:2]] : 32'hffff_ffff;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= ~s_axi_rdata;
            s_axi_rresp <= ~s_axi_rresp;
         end
      end
   end
endmodule : axu_slave_model

// *** axu_access_fsm_test.sv ***
`timescale 1ns/1ps
module axu_access_fsm_test;
   logic core_clk, rstn, rd_req, wr_req, done, busy, rd_err, wr_err;
   logic [31:0] addr, wdata, rdata, aw_a, w_d, ar_a, r_d;
   logic [3:0] wstrb, slow, w_s;
   logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
   logic [1:0] b_resp, r_resp;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   axu_access_fsm i_axu_access_fsm (.core_clk(core_clk), .rstn(rstn),
      .user_read_req(rd_req), .user_write_req(wr_req), .user_addr(addr),
      .user_wdata(wdata), .user_wstrb(wstrb), .user_done(done),
      .user_rdata(rdata), .user_rd_err(rd_err), .user_wr_err(wr_err),
      .user_busy(busy), .s_axi_awvalid(aw_v), .s_axi_awaddr(aw_a),
      .s_axi_awready(aw_r), .s_axi_wvalid(w_v), .s_axi_wdata(w_d),
      .s_axi_wstrb(w_s), .s_axi_wready(w_r), .s_axi_bresp(b_resp),
      .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_arvalid(ar_v),
      .s_axi_araddr(ar_a), .s_axi_arready(ar_r), .s_axi_rdata(r_d),
      .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r));
   axu_slave_model i_axu_slave_model (.core_clk(core_clk), .rstn(rstn),
      .wait_cyc(slow), .s_axi_awvalid(aw_v), .s_axi_awaddr(aw_a),
      .s_axi_awready(aw_r), .s_axi_wvalid(w_v), .s_axi_wdata(w_d),
      .s_axi_wstrb(w_s), .s_axi_wready(w_r), .s_axi_bresp(b_resp),
      .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_arvalid(ar_v),
      .s_axi_araddr(ar_a), .s_axi_arready(ar_r), .s_axi_rdata(r_d),
      .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   // one access; latency counted in falling edges after the taking edge
   task automatic acc(input logic rd, input logic both, input logic [31:0] a,
      input logic [31:0] d, input logic [3:0] st, input logic [3:0] w,
      input logic [31:0] erd, input logic ere, input logic ewe);
      int n;
      slow = w;
      {rd_req, wr_req, addr, wdata, wstrb} = {rd, both | !rd, a, d, st};
      for (n = 1; n < 40; n++) begin
         @(negedge core_clk);
         if (n == 1) begin
            {rd_req, wr_req} = 2'b00;
            check(busy, 1'b1);
         end
         if (n == 2 && rd)
            check({ar_v, r_r, aw_v}, 3'b110);
         if (n == 2 && !rd)
            check({aw_v, w_v, b_r, ar_v}, 4'he);
         if (n == 2 && !rd) check({w_d, w_s}, {d, st});
         if (n == 2 + w)
            check(rd ? {ar_v, ar_a} : {aw_v, aw_a}, {1'b1, a});
         if (n == 3 + w) check(rd ? ar_v : aw_v | w_v, 1'b0);
         if (done === 1'b1) break;
      end
      // model's registered ready: taken, accept, drop with response, ack, done
      check(n, 5 + w);
      check({busy, b_r, r_r}, 3'b000);
      check({rd_err, wr_err}, {ere, ewe});
      if (rd) check(rdata, erd);
      @(negedge core_clk);
      check(done, 1'b0);
   endtask : acc
   task automatic mid_reset();
      {wr_req, addr, slow} = {1'b1, 32'h0, 4'h5};
      @(negedge core_clk);
      wr_req = 1'b0;
      @(negedge core_clk);
      rstn = 1'b0;
      #1 check({busy, wr_err}, 2'b11);
      @(negedge core_clk);
      check({busy, aw_v, w_v, b_r, wr_err, done}, 6'h0);
      rstn = 1'b1;
   endtask : mid_reset
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 1500) begin
         err_total++;
         report_and_stop();
      end
   end
   initial begin
      {rstn, rd_req, wr_req, addr, wdata, wstrb, slow} = '0;
      repeat (20) @(negedge core_clk);
      check({busy, done, rd_err, wr_err, aw_v, w_v, ar_v}, 7'h0);
      check({rdata, b_r, r_r}, 34'h0);
      rstn = 1'b1;
      acc(0, 0, 32'hc, 32'h1122_3344, 4'hf, 0, 0, 0, 0);
      acc(0, 0, 32'hc, 32'haabb_ccdd, 4'h5, 3, 0, 0, 0);
      acc(1, 1, 32'hc, 0, 0, 2, 32'h11bb_33dd, 0, 0);
      acc(0, 0, 32'h100, 32'h1, 4'hf, 1, 0, 0, 1);
      acc(1, 0, 32'h104, 0, 0, 0, 32'hffff_ffff, 1, 1);
      acc(1, 0, 32'h9000_0000, 0, 0, 0, 32'hffff_ffff, 0, 1);
      acc(1, 0, 32'hb000_0000, 0, 0, 1, 32'hffff_ffff, 0, 1);
      mid_reset();
      acc(0, 0, 32'h0, 32'h5, 4'hf, 0, 0, 0, 0);
      acc(1, 0, 32'h0, 0, 0, 4, 32'h5, 0, 0);
      report_and_stop();
   end
endmodule : axu_access_fsm_test
